// *** core/wdsup_consts.vh ***
// Purpose: Constants for the windowed watchdog reset supervisor.
// Assumes: 40 MHz system clock; one-millisecond timebase tick.
// Notes:   Times are given in their own unit; only the tick period is converted to cycles here.
`ifndef WDSUP_CONSTS_VH
`define WDSUP_CONSTS_VH

// ****************************************************************
// Timebase
// ****************************************************************
`define WDSUP_CLK_HZ          40000000
`define WDSUP_TICK_US         1000
`define WDSUP_TICK_CYC        ((`WDSUP_CLK_HZ / 1000000) * `WDSUP_TICK_US)
`define WDSUP_TICK_W          16

// ****************************************************************
// Timeouts in milliseconds (tick units)
// ****************************************************************
`define WDSUP_FIXED_WD_MS     280
`define WDSUP_FIXED_RST_MS    13
`define WDSUP_CNT_W           20

// ****************************************************************
// Window ratio strap codes {sel1, sel0} and shift amounts
// ****************************************************************
`define WDSUP_RATIO_8         2'b00
`define WDSUP_RATIO_16        2'b10
`define WDSUP_RATIO_64        2'b11
`define WDSUP_RATIO_OFF       2'b01
`define WDSUP_SHIFT_8         3
`define WDSUP_SHIFT_16        4
`define WDSUP_SHIFT_64        6

// ****************************************************************
// Timing pin strap codes
// ****************************************************************
`define WDSUP_PIN_CAP         2'b00
`define WDSUP_PIN_GND         2'b01
`define WDSUP_PIN_OUT         2'b10

`endif

// *** core/wdsup_tick.v ***
// Purpose: Divider giving a one-cycle tick pulse from the system clock.
// Assumes: Synchronous enable-based slow timing.
// Notes:   The period is a parameter so simulation can shorten it.
`timescale 1ns/1ps
`include "wdsup_consts.vh"

module wdsup_tick #(
    parameter TICK_CYC = `WDSUP_TICK_CYC
) (
    // Clock and reset.
    input  wire clk_sys,
    input  wire reset,
    // Tick output.
    output reg  tick_q
);

    reg [`WDSUP_TICK_W-1:0] div_q;

    // Count up and pulse the tick once per period.
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            div_q  <= {`WDSUP_TICK_W{1'b0}};
            tick_q <= 1'b0;
        end
        else if (div_q == TICK_CYC[`WDSUP_TICK_W-1:0] - 16'h0001)
        begin
            div_q  <= {`WDSUP_TICK_W{1'b0}};
            tick_q <= 1'b1;
        end
        else
        begin
            div_q  <= div_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

endmodule

// *** core/wdsup_top.v ***
// Purpose: Windowed watchdog and voltage reset supervisor, active-low reset out.
// Assumes: All inputs synchronous to clk_sys; comparators arrive as logic levels.
// Notes:   Capacitor timing is given as tick counts on ports.
//
// Overview of operation
// R01: Windowed: too-fast or too-slow strobe asserts reset.
// R02: Fast limit is slow limit over strap ratio.
// R03: Strap decode: 8, 16, 64, or disabled.
// R04: Strobe edges ignored while reset asserted.
// R05: Interval counter idle during reset, restarts after.
// R06: Interval counter cleared when reset asserts.
// R07: Boundary intervals need no guaranteed behaviour.
// R08: Processor strobes inside the valid window.
// R09: Windowed: sel0 high, sel1 low disables watchdog.
// R10: Non-windowed: disable input low stops watchdog.
// R11: Low load current disables the watchdog.
// R12: Re-enable only above upper current threshold.
// R13: Watchdog resumes at once unless reset asserted.
// R14: Reset timing pin grounded holds reset low.
// R15: Reset timing pin to output: fixed timeout.
// R16: Capacitor reset timeout scales with capacitance.
// R17: Capacitor slow limit scales with capacitance.
// R18: Watchdog timing pin to output: fixed timeout.
// R19: Fixed watchdog timeout at least 280 ms.
// R20: Non-windowed: each edge clears the interval counter.
// R21: Undervoltage holds reset, then timeout after recovery.
// R22: Comparators are inputs; timeouts from internal timebase.
`timescale 1ns/1ps
`include "wdsup_consts.vh"

module wdsup_top #(
    parameter WINDOWED     = 1,
    parameter TICK_CYC     = `WDSUP_TICK_CYC,
    parameter FIXED_WD_MS  = `WDSUP_FIXED_WD_MS,
    parameter FIXED_RST_MS = `WDSUP_FIXED_RST_MS
) (
    // Clock and reset.
    input  wire                    clk_sys,
    input  wire                    reset,
    // Processor strobe and watchdog straps.
    input  wire                    watchdog_strobe_in,
    input  wire                    window_ratio_sel0,
    input  wire                    window_ratio_sel1,
    input  wire                    watchdog_off_n,
    // Timing pin straps and capacitor-derived times in ticks.
    input  wire [1:0]              reset_delay_cap_pin,
    input  wire [1:0]              watchdog_delay_cap_pin,
    input  wire [`WDSUP_CNT_W-1:0] reset_cap_ticks,
    input  wire [`WDSUP_CNT_W-1:0] watchdog_cap_ticks,
    // Analog comparator results.
    input  wire                    output_below_threshold,
    input  wire                    load_below_disable,
    input  wire                    load_above_enable,
    // Supervisor outputs.
    output reg                     reset_out_n_q,
    output reg                     watchdog_active_q
);

    // ****************************************************************
    // Timebase and straps
    // ****************************************************************

    wire                    tick;
    reg                     strobe_q;
    reg                     low_load_q;
    reg                     hold_q;
    reg [`WDSUP_CNT_W-1:0]  wd_cnt_q;
    reg [`WDSUP_CNT_W-1:0]  rst_cnt_q;
    reg [`WDSUP_CNT_W-1:0]  slow_lim;
    reg [`WDSUP_CNT_W-1:0]  fast_lim;
    reg [`WDSUP_CNT_W-1:0]  rst_lim;
    reg                     strap_off;
    reg                     wd_fault;

    // Internal timebase tick for all timeouts.
    wdsup_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .clk_sys (clk_sys),
        .reset   (reset),
        .tick_q  (tick)
    ); // R22

    wire strobe_edge = (watchdog_strobe_in != strobe_q);
    wire wd_enabled  = !strap_off && !low_load_q; // R13

    // Select limits from the timing pins and the ratio straps.
    always @*
    begin
        if (watchdog_delay_cap_pin == `WDSUP_PIN_OUT)
            slow_lim = FIXED_WD_MS[`WDSUP_CNT_W-1:0]; // R18 R19
        else
            slow_lim = watchdog_cap_ticks; // R17
        if (reset_delay_cap_pin == `WDSUP_PIN_OUT)
            rst_lim = FIXED_RST_MS[`WDSUP_CNT_W-1:0]; // R15
        else
            rst_lim = reset_cap_ticks; // R16
        fast_lim  = slow_lim >> `WDSUP_SHIFT_8;
        strap_off = 1'b0;
        if (WINDOWED != 0)
        begin
            case ({window_ratio_sel1, window_ratio_sel0}) // R03
                `WDSUP_RATIO_8:  fast_lim = slow_lim >> `WDSUP_SHIFT_8; // R02
                `WDSUP_RATIO_16: fast_lim = slow_lim >> `WDSUP_SHIFT_16;
                `WDSUP_RATIO_64: fast_lim = slow_lim >> `WDSUP_SHIFT_64;
                default:         strap_off = 1'b1; // R09
            endcase
        end
        else
            strap_off = !watchdog_off_n; // R10
    end

    // Fault when an edge comes too early in a windowed build, or the slow limit is reached.
    always @*
    begin
        wd_fault = 1'b0;
        if (wd_enabled && !hold_q)
        begin
            if (wd_cnt_q >= slow_lim)
                wd_fault = 1'b1; // R01 R20
            else if ((WINDOWED != 0) && strobe_edge && (wd_cnt_q < fast_lim))
                wd_fault = 1'b1; // R01 R07
        end
    end

    // ****************************************************************
    // Load-current disable with hysteresis
    // ****************************************************************

    // Set below the low threshold; clear only above the high one.
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            low_load_q <= 1'b0;
        else if (load_below_disable)
            low_load_q <= 1'b1; // R11
        else if (load_above_enable)
            low_load_q <= 1'b0; // R12
    end

    // ****************************************************************
    // Reset hold and watchdog interval counting
    // ****************************************************************

    // Reset hold: undervoltage or fault starts, timeout releases it.
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            hold_q    <= 1'b1;
            rst_cnt_q <= {`WDSUP_CNT_W{1'b0}};
        end
        else if (output_below_threshold || wd_fault ||
                 reset_delay_cap_pin == `WDSUP_PIN_GND)
        begin
            hold_q    <= 1'b1; // R14 R21
            rst_cnt_q <= {`WDSUP_CNT_W{1'b0}};
        end
        else if (hold_q && tick)
        begin
            if (rst_cnt_q + 20'h00001 >= rst_lim)
                hold_q <= 1'b0; // R21
            rst_cnt_q <= rst_cnt_q + 20'h00001;
        end
    end

    // Interval counter: cleared in reset, ignores strobes during it.
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            wd_cnt_q <= {`WDSUP_CNT_W{1'b0}};
            strobe_q <= 1'b0;
        end
        else
        begin
            strobe_q <= watchdog_strobe_in;
            if (hold_q || wd_fault || !wd_enabled)
                wd_cnt_q <= {`WDSUP_CNT_W{1'b0}}; // R04 R05 R06
            else if (strobe_edge)
                wd_cnt_q <= {`WDSUP_CNT_W{1'b0}}; // R20
            else if (tick)
                wd_cnt_q <= wd_cnt_q + 20'h00001; // R13
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************

    // Outputs follow the hold flag and enable state.
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            reset_out_n_q     <= 1'b0;
            watchdog_active_q <= 1'b0;
        end
        else
        begin
            reset_out_n_q     <= !hold_q;
            watchdog_active_q <= wd_enabled && !hold_q;
        end
    end

endmodule

// *** testbench/wdsup_properties.sv ***
// Purpose: Port assertions for the watchdog supervisor.
// Assumes: Windowed build; inputs held a few cycles at a time.
// Notes:   Five-cycle runs cover input and output registering.
`timescale 1ns/1ps
`include "wdsup_consts.vh"
module wdsup_chk (
    // Clock and reset.
    input wire                    clk_sys,
    input wire                    reset,
    // Straps and comparators.
    input wire                    window_ratio_sel0,
    input wire                    window_ratio_sel1,
    input wire [1:0]              reset_delay_cap_pin,
    input wire [`WDSUP_CNT_W-1:0] reset_cap_ticks,
    input wire                    output_below_threshold,
    input wire                    load_below_disable,
    // Supervisor outputs.
    input wire                    reset_out_n_q,
    input wire                    watchdog_active_q
);
    // All checks use the system clock and sleep during reset.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_release_low: assert property ($fell(reset) |-> !reset_out_n_q [*2])
        else $error("reset output high at release");
    a_ground_hold: assert property ((reset_delay_cap_pin == 2'b01) [*5] |-> !reset_out_n_q)
        else $error("reset output high with grounded timing pin");
    a_under_hold: assert property (output_below_threshold [*5] |-> !reset_out_n_q)
        else $error("reset output high under threshold");
    a_strap_off: assert property (({window_ratio_sel1, window_ratio_sel0} == 2'b01) [*5]
        |-> !watchdog_active_q)
        else $error("watchdog active with off straps");
    a_load_off: assert property (load_below_disable [*5] |-> !watchdog_active_q)
        else $error("watchdog active at low load");
    a_hold_min: assert property (($fell(reset_out_n_q) && reset_delay_cap_pin == 2'b00
        && reset_cap_ticks > 20'h1) |=> !reset_out_n_q [*4])
        else $error("reset pulse too short");
    a_active_drop: assert property ($fell(reset_out_n_q) |-> ##[0:2] !watchdog_active_q)
        else $error("watchdog still active after reset");
    a_hold_quiet: assert property (!reset_out_n_q [*5] |-> !watchdog_active_q)
        else $error("watchdog active while reset held");
endmodule
bind wdsup_top wdsup_chk i_wdsup_chk (.clk_sys, .reset, .window_ratio_sel0,
    .window_ratio_sel1, .reset_delay_cap_pin, .reset_cap_ticks, .output_below_threshold,
    .load_below_disable, .reset_out_n_q, .watchdog_active_q);

// *** testbench/wdsup_cpu_model.sv ***
// Purpose: Processor that strobes the watchdog and obeys reset.
// Assumes: Period in clock cycles; zero means silent.
// Notes:   Count restarts whenever reset is held.
`timescale 1ns/1ps
module wdsup_cpu_model (
    // Clock and reset from the supervisor.
    input  wire        clk_sys,
    input  wire        reset_out_n_q,
    // Strobe period and strobe.
    input  wire [15:0] period,
    output reg         strobe_q
);
    reg [15:0] cnt_q;
    initial strobe_q = 1'b0;
    // Toggles the strobe each period while out of reset.
    always @(posedge clk_sys)
    begin
        if (!reset_out_n_q || period == 16'h0)
            cnt_q <= 16'h1;
        else if (cnt_q >= period)
        begin
            cnt_q    <= 16'h1;
            strobe_q <= ~strobe_q;
        end
        else
            cnt_q <= cnt_q + 16'h1;
    end
endmodule

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the watchdog supervisor.
// Assumes: Tick of 4 cycles; slow limit 128 ticks, hold 8 ticks.
// Notes:   Fast limits are 64, 32 and 8 cycles; fixed hold 3, fixed slow 64 ticks.
`timescale 1ns/1ps
module testbench;
    reg         clk_sys = 1'b0;
    reg         reset = 1'b1;
    reg  [1:0]  sel = 2'b00;
    reg  [1:0]  rst_pin = 2'b00;
    reg  [1:0]  wd_pin = 2'b00;
    reg         below = 1'b0;
    reg         ld_lo = 1'b0;
    reg         ld_hi = 1'b0;
    reg  [15:0] period = 16'h0;
    reg  [18:0] rows [0:7];
    reg         seen;
    wire        strobe;
    wire        rst_n;
    wire        active;
    integer     fails = 0;
    integer     n_compared = 0;
    integer     i;
    integer     k;
    always #12.5 clk_sys = ~clk_sys;
    wdsup_top #(.TICK_CYC(4), .FIXED_WD_MS(64), .FIXED_RST_MS(3)) i_wdsup_top (.clk_sys(clk_sys),
        .reset(reset), .watchdog_strobe_in(strobe), .window_ratio_sel0(sel[0]),
        .window_ratio_sel1(sel[1]), .watchdog_off_n(1'b1), .reset_delay_cap_pin(rst_pin),
        .watchdog_delay_cap_pin(wd_pin), .reset_cap_ticks(20'h8), .watchdog_cap_ticks(20'h80),
        .output_below_threshold(below), .load_below_disable(ld_lo),
        .load_above_enable(ld_hi), .reset_out_n_q(rst_n), .watchdog_active_q(active));
    wdsup_cpu_model i_wdsup_cpu_model (.clk_sys(clk_sys), .reset_out_n_q(rst_n),
        .period(period), .strobe_q(strobe));
    task complete_run;
    begin
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    task chk(input string name, input exp, input got);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("MISMATCH %0s expected %b seen %b", name, exp, got);
        end
    end
    endtask
    // Waits a bounded time for the reset output to release.
    task wait_high;
    begin
        k = 0;
        while (rst_n !== 1'b1 && k < 400)
        begin
            @(negedge clk_sys);
            k = k + 1;
        end
        if (k == 400)
        begin
            fails = fails + 1;
            complete_run;
        end
    end
    endtask
    // Watches n cycles and notes any reset pulse.
    task watch(input integer n);
    begin
        seen = 1'b0;
        repeat (n)
        begin
            @(negedge clk_sys);
            seen = seen | (rst_n === 1'b0);
        end
    end
    endtask
    initial
    begin
        rows[0] = {2'b00, 16'd100, 1'b0};
        rows[1] = {2'b00, 16'd40, 1'b1};
        rows[2] = {2'b10, 16'd40, 1'b0};
        rows[3] = {2'b10, 16'd20, 1'b1};
        rows[4] = {2'b11, 16'd20, 1'b0};
        rows[5] = {2'b11, 16'd4, 1'b1};
        rows[6] = {2'b00, 16'd0, 1'b1};
        rows[7] = {2'b01, 16'd0, 1'b0};
        repeat (8) @(negedge clk_sys);
        reset = 1'b0;
        chk("hold", 1'b0, rst_n);
        for (i = 0; i < 8; i = i + 1)
        begin
            {sel, period} = rows[i][18:1];
            @(negedge clk_sys) reset = 1'b1;
            @(negedge clk_sys) reset = 1'b0;
            wait_high;
            watch(700);
            chk("fault", rows[i][0], seen);
        end
        sel = 2'b00;
        period = 16'd100;
        rst_pin = 2'b10;
        below = 1'b1;
        watch(20);
        chk("under", 1'b0, rst_n);
        below = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk("fixhold", 1'b0, rst_n);
        // The fixed hold of 3 ticks ends well before the 8-tick capacitor hold would.
        repeat (10) @(negedge clk_sys);
        chk("fixdone", 1'b1, rst_n);
        wait_high;
        rst_pin = 2'b01;
        watch(200);
        chk("ground", 1'b0, rst_n);
        rst_pin = 2'b00;
        wait_high;
        period = 16'h0;
        ld_lo = 1'b1;
        repeat (10) @(negedge clk_sys);
        ld_lo = 1'b0;
        watch(700);
        chk("lowload", 1'b0, seen | active);
        period = 16'd100;
        ld_hi = 1'b1;
        repeat (4) @(negedge clk_sys);
        ld_hi = 1'b0;
        chk("resume", 1'b1, active);
        watch(300);
        chk("running", 1'b0, seen);
        // A silent processor with the fixed slow limit of 64 ticks faults within 300 cycles.
        period = 16'h0;
        wd_pin = 2'b10;
        watch(300);
        chk("fixwd", 1'b1, seen);
        complete_run;
    end
endmodule
